// ==== src/scr_ctl_if.sv ====
// Configuration fields and access inputs passed from the register bank to the decode module, and decode results back.
// Assumes one clock domain.
`timescale 1ns/10ps
interface scr_ctl_if;
    logic [1:0]  show_sel;
    logic        placement;
    logic        privilege;
    logic [23:0] access_addr;
    logic        access_super;
    logic        module_hit;
    logic        access_denied;
    logic        show_drive;
    logic        arb_allow;
    modport regs (output show_sel, output placement, output privilege,
                  output access_addr, output access_super,
                  input module_hit, input access_denied, input show_drive,
                  input arb_allow);
    modport dec (input show_sel, input placement, input privilege,
                 input access_addr, input access_super,
                 output module_hit, output access_denied, output show_drive,
                 output arb_allow);
endinterface

// ==== src/scr_decode.sv ====
// Combinational decode of show-cycle mode, module placement and privilege.
// Assumes fields come from registered configuration state.
`timescale 1ns/10ps
`include "scr_map.svh"
module scr_decode (
    // Configuration fields
    scr_ctl_if.dec ctl
);
    import scr_pkg::*;

    function automatic logic place_hit(input logic [23:0] a, input logic p);
        place_hit = (a & `SCR_PLACE_MASK) == (p ? `SCR_PLACE_BASE1 : `SCR_PLACE_BASE0);
    endfunction

    scr_show_type mode;
    assign mode = scr_show_type'(ctl.show_sel);

    assign ctl.module_hit    = place_hit(ctl.access_addr, ctl.placement);
    assign ctl.access_denied = ctl.module_hit & ctl.privilege & ~ctl.access_super;

    always_comb begin
        case (mode)
            SCR_SHOW_OFF_ARB: begin
                ctl.show_drive = 1'b0;
                ctl.arb_allow  = 1'b1;
            end
            SCR_SHOW_ON_NOARB: begin
                ctl.show_drive = 1'b1;
                ctl.arb_allow  = 1'b0;
            end
            default: begin
                ctl.show_drive = 1'b1;
                ctl.arb_allow  = 1'b1;
            end
        endcase
    end
endmodule

// ==== src/scr_map.svh ====
// System configuration register map: offsets, field positions, reset values.
// Assumes inclusion by the package and by each module that decodes the fields.
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH
// -----------------------------------------------------------------------------
// Offsets
// -----------------------------------------------------------------------------
`define SCR_OFS_CONFIG      12'h000
`define SCR_OFS_CONTROL     12'h004
// -----------------------------------------------------------------------------
// Configuration word fields
// -----------------------------------------------------------------------------
`define SCR_BIT_CLKOFF      15
`define SCR_BIT_FRZTMR      14
`define SCR_BIT_FREEZE_BUS_MONITOR       13
`define SCR_BIT_EXTMST      11
`define SCR_BIT_SHOW_HI     9
`define SCR_BIT_SHOW_LO     8
`define SCR_BIT_PRIV        7
`define SCR_BIT_PLACE       6
`define SCR_BIT_ARB_HI      3
`define SCR_BIT_ARB_LO      0
`define SCR_ARB_RESET       4'hF
`define SCR_WRITE_MASK      16'hE3CF
// -----------------------------------------------------------------------------
// Control word fields and placement decode addresses
// -----------------------------------------------------------------------------
`define SCR_CTL_CLKDIV_BIT  0
`define SCR_PLACE_BASE0     24'h7FF000
`define SCR_PLACE_BASE1     24'hFFF000
`define SCR_PLACE_MASK      24'hFFF000
`endif

// ==== src/scr_pkg.sv ====
// Types shared by the system configuration register bank.
// Assumes the map header is on the include path.
package scr_pkg;
    `include "scr_map.svh"
    typedef enum logic [1:0] {
        SCR_SHOW_OFF_ARB,
        SCR_SHOW_ON_NOARB,
        SCR_SHOW_ON_ARB,
        SCR_SHOW_ON_ARB_HALT
    } scr_show_type;
    typedef enum {
        SCR_PLACE_OPEN,
        SCR_PLACE_LOCKED
    } scr_lock_type;
endpackage

// ==== src/scr_top.sv ====
// System configuration register bank with APB slave and derived controls.
// Assumes a synchronous APB master on pclk; data line eleven is a pin.
//
// How it works
// - The configuration word is readable and writable at any time, placement and external-master-access aside.
// - The placement bit takes the first write after reset and ignores all later ones.
// - Clock-output-disable at 0 drives the clock pin, at 1 floats it.
// - Freeze-timers at 1 halts watchdog and interval timer while freeze is high.
// - Freeze-bus-monitor at 1 disables the bus monitor while freeze is high.
// - External-master-access is read-only and captured from data line eleven in reset.
// - External-master-access at 1 opens the internal module bus to an outside master.
// - The two-bit show field sets show-cycle driving and arbitration.
// - Show 00 means no show cycles with arbitration; 01 show cycles without arbitration.
// - Show 10 means show cycles with arbitration; 11 also halts on a bus grant.
// - Placement 0 decodes 0x7FF000 to 0x7FFFFF, placement 1 decodes 0xFFF000 to 0xFFFFFF.
// - Privilege bit at 1 admits only supervisor accesses to protected registers.
// - The arbitration field resets to 1111; zero prevents arbitration.
`timescale 1ns/10ps
`include "scr_map.svh"
module scr_top (
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Pins
    input  wire logic        data_line_eleven,
    input  wire logic        freeze,
    output logic             clock_output_pin,
    output logic             clock_output_pin_oe,
    // Internal module bus access check
    input  wire logic [23:0] access_addr,
    input  wire logic        access_super,
    output logic             module_hit,
    output logic             access_denied,
    // Derived controls
    input  wire logic        bus_grant,
    output logic             timers_halt,
    output logic             bus_monitor_enable,
    output logic             external_master_access,
    output logic             show_drive,
    output logic             arb_allow,
    output logic             internal_halt,
    output logic [3:0]       interrupt_arbitration_level,
    output logic             arbitration_enabled
);
    import scr_pkg::*;

    // -------------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------------
    logic [15:0]  cfg_ff;
    logic         xmst_ff;
    logic [2:0]   d11_sync_ff;
    logic [2:0]   frz_sync_ff;
    logic         frz_ff;
    logic         clkdiv_ff;
    logic         clkdiv_sel_ff;
    logic         div_ff;
    scr_lock_type lock_ff;
    logic [31:0]  prdata_ff;
    logic [15:0]  nxt_cfg;

    wire wr_access = psel & penable & pwrite;
    wire rd_setup  = psel & ~penable & ~pwrite;
    wire hit_cfg   = paddr == `SCR_OFS_CONFIG;
    wire hit_ctl   = paddr == `SCR_OFS_CONTROL;

    scr_ctl_if ctl ();
    scr_decode scr_decode_inst (
        .ctl (ctl)
    );

    // -------------------------------------------------------------------------
    // Bus slave
    // -------------------------------------------------------------------------
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~(hit_cfg | hit_ctl);
    assign prdata  = prdata_ff;

    always_comb begin
        nxt_cfg = cfg_ff;
        if (wr_access && hit_cfg) begin
            nxt_cfg = (cfg_ff & ~`SCR_WRITE_MASK) | (pwdata[15:0] & `SCR_WRITE_MASK);
            if (lock_ff == SCR_PLACE_LOCKED) begin
                nxt_cfg[`SCR_BIT_PLACE] = cfg_ff[`SCR_BIT_PLACE];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= {8'h00, 4'hC, `SCR_ARB_RESET};
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_ff <= SCR_PLACE_OPEN;
        end else if (wr_access && hit_cfg) begin
            lock_ff <= SCR_PLACE_LOCKED;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clkdiv_sel_ff <= 1'b0;
        end else if (wr_access && hit_ctl) begin
            clkdiv_sel_ff <= pwdata[`SCR_CTL_CLKDIV_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_ff <= hit_cfg ? {16'h0000, cfg_ff[15:12], xmst_ff, cfg_ff[10:0]} :
                         hit_ctl ? {31'h0000_0000, clkdiv_sel_ff} : 32'h0000_0000;
        end
    end

    // -------------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frz_sync_ff <= 3'h0;
            frz_ff      <= 1'b0;
        end else begin
            frz_sync_ff <= {frz_sync_ff[1:0], freeze};
            if (frz_sync_ff[1] == frz_sync_ff[2]) begin
                frz_ff <= frz_sync_ff[2];
            end
        end
    end

    // The strap chain has no reset, because it must keep sampling while reset is low.
    always_ff @(posedge pclk) begin
        d11_sync_ff <= {d11_sync_ff[1:0], data_line_eleven};
    end

    // strap capture in reset
    // The strap is sampled by the clock while reset is low and frozen once it is
    // released; writes never reach it.
    always_ff @(posedge pclk) begin
        if (!presetn && d11_sync_ff[1] == d11_sync_ff[2]) begin
            xmst_ff <= d11_sync_ff[2];
        end
    end

    // -------------------------------------------------------------------------
    // Clock output
    // -------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clkdiv_ff <= 1'b0;
            div_ff    <= 1'b0;
        end else begin
            clkdiv_ff <= ~clkdiv_ff;
            div_ff    <= clkdiv_sel_ff ? ~div_ff & clkdiv_ff | div_ff & ~clkdiv_ff : clkdiv_ff;
        end
    end

    assign clock_output_pin    = div_ff;
    assign clock_output_pin_oe = ~cfg_ff[`SCR_BIT_CLKOFF];

    // -------------------------------------------------------------------------
    // Derived controls
    // -------------------------------------------------------------------------
    // timers freeze
    assign timers_halt            = cfg_ff[`SCR_BIT_FRZTMR] & frz_ff;
    assign bus_monitor_enable     = ~(cfg_ff[`SCR_BIT_FREEZE_BUS_MONITOR] & frz_ff);
    assign external_master_access = xmst_ff;

    assign ctl.show_sel     = cfg_ff[`SCR_BIT_SHOW_HI:`SCR_BIT_SHOW_LO];
    assign ctl.placement    = cfg_ff[`SCR_BIT_PLACE];
    assign ctl.privilege    = cfg_ff[`SCR_BIT_PRIV];
    assign ctl.access_addr  = access_addr;
    assign ctl.access_super = access_super;
    assign module_hit       = ctl.module_hit;
    assign access_denied    = ctl.access_denied;
    assign show_drive       = ctl.show_drive;
    assign arb_allow        = ctl.arb_allow;
    assign internal_halt    = (ctl.show_sel == 2'h3) & bus_grant;
    assign interrupt_arbitration_level = cfg_ff[`SCR_BIT_ARB_HI:`SCR_BIT_ARB_LO];
    assign arbitration_enabled = |cfg_ff[`SCR_BIT_ARB_HI:`SCR_BIT_ARB_LO];

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    // Freeze pin held long enough to have passed the synchroniser.
    sequence s_frz_held;
        freeze [*5];
    endsequence

    property p_wr_takes;
        @(posedge pclk) disable iff (!presetn)
        wr_access && hit_cfg |=> cfg_ff[15:13] == $past(pwdata[15:13]);
    endproperty
    a_wr_takes: assert property (p_wr_takes) else $error("config write lost");

    property p_place_once;
        @(posedge pclk) disable iff (!presetn)
        lock_ff == SCR_PLACE_LOCKED |=> $stable(cfg_ff[`SCR_BIT_PLACE]);
    endproperty
    a_place_once: assert property (p_place_once) else $error("placement rewritten");

    property p_clk_float;
        @(posedge pclk) disable iff (!presetn)
        wr_access && hit_cfg && pwdata[15] |=> !clock_output_pin_oe;
    endproperty
    a_clk_float: assert property (p_clk_float) else $error("clock pin not floated");

    property p_tmr_frz;
        @(posedge pclk) disable iff (!presetn)
        s_frz_held |-> timers_halt == cfg_ff[`SCR_BIT_FRZTMR];
    endproperty
    a_tmr_frz: assert property (p_tmr_frz) else $error("timers freeze wrong");

    property p_bm_frz;
        @(posedge pclk) disable iff (!presetn)
        s_frz_held |-> bus_monitor_enable == !cfg_ff[`SCR_BIT_FREEZE_BUS_MONITOR];
    endproperty
    a_bm_frz: assert property (p_bm_frz) else $error("bus monitor freeze wrong");

    property p_xmst_ro;
        @(posedge pclk) disable iff (!presetn)
        wr_access ##1 1'b1 |-> $stable(external_master_access);
    endproperty
    a_xmst_ro: assert property (p_xmst_ro) else $error("strap bit changed");

    property p_show01;
        @(posedge pclk) disable iff (!presetn)
        ctl.show_sel == 2'h1 |-> show_drive && !arb_allow;
    endproperty
    a_show01: assert property (p_show01) else $error("show 01 wrong");

    property p_halt11;
        @(posedge pclk) disable iff (!presetn)
        bus_grant && ctl.show_sel != 2'h3 |-> !internal_halt;
    endproperty
    a_halt11: assert property (p_halt11) else $error("spurious halt");

    property p_deny;
        @(posedge pclk) disable iff (!presetn)
        access_denied |-> cfg_ff[`SCR_BIT_PRIV] && !access_super;
    endproperty
    a_deny: assert property (p_deny) else $error("bad denial");
endmodule

// ==== testbench/test_scr_top.sv ====
// Self-checking bench for the system configuration register bank over APB.
// Assumes scr_top, its package, map header and interface are compiled first.
`timescale 1ns/10ps
module test_scr_top;
    // -------------------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------------------
    localparam logic [11:0] CFG = 12'h000;
    logic        pclk               = 1'b0;
    logic        presetn            = 1'b0;
    logic        psel               = 1'b0;
    logic        penable            = 1'b0;
    logic        pwrite             = 1'b0;
    logic [11:0] paddr              = 12'h000;
    logic [31:0] pwdata             = 32'h0000_0000;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        data_line_eleven   = 1'b1;
    logic        freeze             = 1'b0;
    logic        clk_o;
    logic        clk_oe;
    logic [23:0] access_addr        = 24'h000000;
    logic        access_super       = 1'b0;
    logic        module_hit;
    logic        access_denied;
    logic        bus_grant          = 1'b0;
    logic        timers_halt;
    logic        bus_monitor_enable;
    logic        ext_master;
    logic        show_drive;
    logic        arb_allow;
    logic        internal_halt;
    logic [3:0]  arb_level;
    logic        arb_enabled;
    logic [31:0] rd;
    logic        err;
    logic        clk_seen;
    int          n_errors           = 0;
    int          check_count        = 0;

    scr_top scr_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .data_line_eleven(data_line_eleven), .freeze(freeze), .clock_output_pin(clk_o),
        .clock_output_pin_oe(clk_oe), .access_addr(access_addr),
        .access_super(access_super), .module_hit(module_hit),
        .access_denied(access_denied), .bus_grant(bus_grant), .timers_halt(timers_halt),
        .bus_monitor_enable(bus_monitor_enable), .external_master_access(ext_master),
        .show_drive(show_drive), .arb_allow(arb_allow), .internal_halt(internal_halt),
        .interrupt_arbitration_level(arb_level), .arbitration_enabled(arb_enabled)
    );

    always #10 pclk = ~pclk;

    // -------------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // The request is held until pready is seen high or 50 cycles pass, so a slow slave is also served.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdat);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdat;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] addr, input logic [31:0] exp, input string what);
        apb(1'b0, addr, 32'h0000_0000);
        chk(what, exp, rd);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic do_reset(input logic strap);
        @(posedge pclk);
        presetn          <= 1'b0;
        data_line_eleven <= strap;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // -------------------------------------------------------------------------
    // Tests
    // -------------------------------------------------------------------------
    initial begin
        do_reset(1'b1);
        rdc(CFG, 32'h0000_08CF, "config after reset");
        chk("config read error", 32'h0, {31'h0, err});
        chk("clock pin enable", 32'h1, {31'h0, clk_oe});
        chk("arbitration level", 32'hF, {28'h0, arb_level});
        chk("arbitration enabled", 32'h1, {31'h0, arb_enabled});
        chk("external master", 32'h1, {31'h0, ext_master});
        $display("test reset values done");
        apb(1'b1, CFG, 32'hFFFF_FFFF);
        rdc(CFG, 32'h0000_EBCF, "config all ones");
        settle(1);
        chk("clock pin enable", 32'h0, {31'h0, clk_oe});
        apb(1'b1, CFG, 32'h0000_0000);
        rdc(CFG, 32'h0000_0840, "config placement locked");
        settle(1);
        chk("clock pin enable", 32'h1, {31'h0, clk_oe});
        chk("arbitration enabled", 32'h0, {31'h0, arb_enabled});
        chk("external master", 32'h1, {31'h0, ext_master});
        $display("test write and lock done");
        apb(1'b1, CFG, 32'h0000_6000);
        settle(6);
        chk("timers halt", 32'h0, {31'h0, timers_halt});
        chk("bus monitor", 32'h1, {31'h0, bus_monitor_enable});
        @(posedge pclk);
        freeze <= 1'b1;
        settle(6);
        chk("timers halt", 32'h1, {31'h0, timers_halt});
        chk("bus monitor", 32'h0, {31'h0, bus_monitor_enable});
        apb(1'b1, CFG, 32'h0000_0000);
        settle(1);
        chk("timers halt", 32'h0, {31'h0, timers_halt});
        chk("bus monitor", 32'h1, {31'h0, bus_monitor_enable});
        @(posedge pclk);
        freeze <= 1'b0;
        $display("test freeze done");
        @(posedge pclk);
        bus_grant <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, CFG, 32'(s) << 8);
            settle(1);
            chk("show drive", {31'h0, s != 0}, {31'h0, show_drive});
            chk("arb allow", {31'h0, s != 1}, {31'h0, arb_allow});
            chk("internal halt", {31'h0, s == 3}, {31'h0, internal_halt});
        end
        @(posedge pclk);
        bus_grant <= 1'b0;
        settle(1);
        chk("internal halt", 32'h0, {31'h0, internal_halt});
        $display("test show modes done");
        @(posedge pclk);
        access_addr <= 24'hFFF010;
        apb(1'b1, CFG, 32'h0000_0000);
        settle(1);
        chk("module hit", 32'h1, {31'h0, module_hit});
        chk("access denied", 32'h0, {31'h0, access_denied});
        apb(1'b1, CFG, 32'h0000_0080);
        settle(1);
        chk("access denied", 32'h1, {31'h0, access_denied});
        @(posedge pclk);
        access_super <= 1'b1;
        settle(1);
        chk("access denied", 32'h0, {31'h0, access_denied});
        @(posedge pclk);
        access_addr <= 24'h7FF010;
        settle(1);
        chk("module hit", 32'h0, {31'h0, module_hit});
        apb(1'b1, 12'h010, 32'h0000_FFFF);
        chk("unmapped write error", 32'h1, {31'h0, err});
        rdc(12'h010, 32'h0000_0000, "unmapped read data");
        chk("unmapped read error", 32'h1, {31'h0, err});
        rdc(CFG, 32'h0000_08C0, "config after unmapped write");
        $display("test decode and unmapped done");
        apb(1'b1, 12'h004, 32'h0000_0001);
        rdc(12'h004, 32'h0000_0001, "clock select");
        settle(1);
        clk_seen = clk_o;
        settle(2);
        chk("clock pin quarter rate", {31'h0, ~clk_seen}, {31'h0, clk_o});
        apb(1'b1, 12'h004, 32'h0000_0000);
        settle(1);
        clk_seen = clk_o;
        settle(1);
        chk("clock pin half rate", {31'h0, ~clk_seen}, {31'h0, clk_o});
        $display("test clock output done");
        do_reset(1'b0);
        settle(1);
        chk("external master", 32'h0, {31'h0, ext_master});
        apb(1'b1, CFG, 32'h0000_0000);
        apb(1'b1, CFG, 32'h0000_0840);
        rdc(CFG, 32'h0000_0000, "config placement zero");
        settle(1);
        chk("module hit", 32'h1, {31'h0, module_hit});
        @(posedge pclk);
        access_addr <= 24'hFFF010;
        settle(1);
        chk("module hit", 32'h0, {31'h0, module_hit});
        $display("test second reset done");
        report_and_stop();
    end

    // A hang in any wait is cut short here at 5000 cycles, well past the expected 150 or so cycles.
    initial begin
        #100000;
        n_errors++;
        $display("unexpected watchdog expiry: expected end of tests, seen none");
        report_and_stop();
    end
endmodule
